// ==== core/uab_pkg.sv ====
// Constants and types for the auto-rate, single-wire, RS-485 and infrared serial port
package uab_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0c;
  localparam logic [7:0] ADDR_IR_TX = 8'h10;
  localparam logic [7:0] ADDR_IR_RX = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TX_DATA = 8'h1c;
  localparam logic [7:0] ADDR_RX_DATA = 8'h20;
  // Writable bit masks
  localparam logic [7:0] CA_MASK = 8'h03;
  localparam logic [7:0] CB_MASK = 8'h1f;
  // Field positions
  localparam int CA_LOOPBACK = 0;
  localparam int CA_RS485 = 1;
  localparam int CB_RECEIVE_MODE_FIELD = 0;
  localparam int CB_OPEN_DRAIN = 2;
  localparam int CB_RX_EN = 3;
  localparam int CB_TX_EN = 4;
  localparam int CC_COMMUNICATION_MODE_FIELD = 0;
  localparam int CC_PARITY_MODE_FIELD = 2;
  localparam int CC_IRTX = 4;
  localparam int CC_IRSRC = 6;
  localparam int CC_STOP2 = 7;
  localparam int ST_WFB = 0;
  localparam int ST_ISF = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_RX_VALID = 3;
  localparam int RD_PARITY_ERROR_FLAG = 8;
  localparam int RD_VALID = 9;
  // Field encodings
  localparam logic [1:0] RXM_DOUBLE = 2'h1;
  localparam logic [1:0] RXM_GENERIC_AUTORATE_MODE = 2'h2;
  localparam logic [1:0] RXM_LIN_AUTORATE_MODE = 2'h3;
  localparam logic [1:0] COMMUNICATION_MODE_FIELD_INFRARED = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [1:0] IRTX_3_16 = 2'h0;
  localparam logic [1:0] IRTX_FIXED = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values and limits
  localparam logic [15:0] BAUD_RESET = 16'h0800;
  localparam logic [7:0] IR_RX_MIN_RESET = 8'h04;
  localparam logic [16:0] BAUD_MIN = 17'h00064;
  localparam logic [16:0] BAUD_MAX = 17'h0ffff;
  localparam logic [16:0] AB_SAT = 17'h1ffff;
  localparam logic [4:0] BREAK_MIN = 5'h0c;
  localparam logic [2:0] SYNC_LAST_FALL = 3'h4;
  localparam logic [3:0] SPB_NORMAL_LAST = 4'hf;
  localparam logic [3:0] SPB_DOUBLE_LAST = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam int TICK_SHIFT = 7;
  localparam int IR_HOLD_SHIFT_A = 4;
  localparam int IR_HOLD_SHIFT_B = 6;
  typedef enum logic [2:0] {R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3,
    R_STOP = 3'h4, R_BREAK = 3'h5, R_SYNC = 3'h6} uab_rx_state_t;
  typedef enum logic [2:0] {T_IDLE = 3'h0, T_GUARD = 3'h1, T_START = 3'h2, T_DATA = 3'h3,
    T_PAR = 3'h4, T_STOP = 3'h5} uab_tx_state_t;
endpackage : uab_pkg

// ==== core/uab_top.sv ====
// Serial port with auto-rate detection, single-wire, RS-485 direction and infrared coding
// Behaviour
// - In auto modes, a zero character with the line low twelve or more clocks is a break; next character is sync.
// - From sync start bit, clocks over eight bit times become the new divisor.
// - Generic auto mode with wait-for-break set accepts a break of any length.
// - Generic auto mode loads the count only if within 0x0064..0xffff.
// - LIN auto mode ignores wait-for-break; break needs twelve low clocks.
// - LIN auto mode: sync other than 0x55 sets inconsistent flag, divisor kept.
// - Loop-back routes the transmit pin to the receiver, receive pin ignored.
// - Open-drain mode only pulls the transmit pin low, never high.
// - Open-drain mode makes the transmit pin an output only while it drives low.
// - In single-wire mode the receiver captures the port's own frames.
// - RS-485 mode drives direction high while sending, low when done.
// - Direction rises one bit time before start, stays high through stop bits.
// - RS-485 direction and loop-back work together.
// - Communication mode 0x02 selects infrared coding on both directions.
// - In infrared mode the pins carry the inverse of the pulse.
// - Infrared receiver may take an event channel instead of the pin.
// - Infrared transmit pulse: 3/16 bit (3/8 bit at double speed), fixed clock width, or unmodulated.
// - Infrared pulses shorter than the minimum width decode as one.
// - Even parity sets the bit for an odd count of ones; odd the reverse.
// - Receiver checks parity and flags a mismatch.
// - LIN auto mode checks only protected identifier parity bits P0 and P1.
// - Receive mode 0x01 is double speed with eight samples per bit.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uab_top import uab_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial pins
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic direction_output_o,
  // Infrared event channel, same clock
  input wire logic ir_event_i
);
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] control_c;
    logic [15:0] baud;
    logic [7:0] ir_tx_width;
    logic [7:0] ir_rx_min;
    logic wait_for_break_bit;
    logic inconsistent_sync_flag;
    logic [7:0] rx_byte;
    logic parity_error_flag;
    logic rx_valid;
    logic rxd_s1;
    logic rxd_s2;
    logic txd_s1;
    logic txd_s2;
    logic line_prev;
    uab_rx_state_t rst;
    logic [15:0] rtick;
    logic [3:0] rsamp;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar_bit;
    logic [4:0] lowcnt;
    logic [16:0] abcnt;
    logic [16:0] abfirst;
    logic [2:0] nfall;
    logic pid_next;
    logic [7:0] irw;
    logic [15:0] irhold;
    logic irdec;
    uab_tx_state_t tst;
    logic [15:0] ttick;
    logic [3:0] tsamp;
    logic [3:0] tbit;
    logic [7:0] tsh;
    logic tpar;
    logic [7:0] irclk;
    logic tpin;
    logic dir;
  } uab_state_t;

  uab_state_t s, next_s;
  logic wr_fire, lb, open_drain_enable_bit, rx_en, tx_en, ir_mode, gen, lin, pm_on, fall, rx_line, pin_line, ir_pulse;
  logic rtk, r_mid, r_end, ttk, t_end, tx_bit, pulse, sync_ok, in_range, rx_deliver;
  logic [1:0] pm;
  logic [3:0] spb_last, mid;
  logic [15:0] tick_len;
  logic [16:0] measured;
  logic [18:0] first4, meas19, diff;
  logic [31:0] wv;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_BAUD, ADDR_IR_TX, ADDR_IR_RX,
      ADDR_STATUS, ADDR_TX_DATA, ADDR_RX_DATA};
  endfunction : mapped

  function automatic logic [31:0] reg_view(input logic [7:0] a, input uab_state_t st);
    reg_view = 32'h0;
    case (a)
      ADDR_CTRL_A: reg_view[7:0] = st.control_a;
      ADDR_CTRL_B: reg_view[7:0] = st.control_b;
      ADDR_CTRL_C: reg_view[7:0] = st.control_c;
      ADDR_BAUD: reg_view[15:0] = st.baud;
      ADDR_IR_TX: reg_view[7:0] = st.ir_tx_width;
      ADDR_IR_RX: reg_view[7:0] = st.ir_rx_min;
      ADDR_STATUS: begin
        reg_view[ST_WFB] = st.wait_for_break_bit;
        reg_view[ST_ISF] = st.inconsistent_sync_flag;
        reg_view[ST_TX_BUSY] = (st.tst != T_IDLE);
        reg_view[ST_RX_VALID] = st.rx_valid;
      end
      ADDR_RX_DATA: begin
        reg_view[7:0] = st.rx_byte;
        reg_view[RD_PARITY_ERROR_FLAG] = st.parity_error_flag;
        reg_view[RD_VALID] = st.rx_valid;
      end
      default: reg_view = 32'h0;
    endcase
  endfunction : reg_view

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge_bytes[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge_bytes

  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] mode);
    parity_of = (mode == PAR_ODD) ? ~^d : ^d;
  endfunction : parity_of

  function automatic logic pid_ok(input logic [7:0] b);
    pid_ok = (b[6] == (b[0] ^ b[1] ^ b[2] ^ b[4])) && (b[7] == ~(b[1] ^ b[3] ^ b[4] ^ b[5]));
  endfunction : pid_ok

  assign s_axi_awready_o = ~s.aw_have & ~s.bvalid;
  assign s_axi_wready_o = ~s.w_have & ~s.bvalid;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = ~s.rvalid;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign direction_output_o = s.dir;
  assign txd_o = open_drain_enable_bit ? 1'b0 : s.tpin;
  assign txd_oe_o = open_drain_enable_bit ? ~s.tpin : tx_en;

  always_comb begin
    next_s = s;
    wv = 32'h0;
    rx_deliver = 1'b0;
    r_mid = 1'b0;
    r_end = 1'b0;
    t_end = 1'b0;
    lb = s.control_a[CA_LOOPBACK];
    open_drain_enable_bit = s.control_b[CB_OPEN_DRAIN];
    rx_en = s.control_b[CB_RX_EN];
    tx_en = s.control_b[CB_TX_EN];
    ir_mode = (s.control_c[CC_COMMUNICATION_MODE_FIELD +: 2] == COMMUNICATION_MODE_FIELD_INFRARED);
    gen = (s.control_b[CB_RECEIVE_MODE_FIELD +: 2] == RXM_GENERIC_AUTORATE_MODE);
    lin = (s.control_b[CB_RECEIVE_MODE_FIELD +: 2] == RXM_LIN_AUTORATE_MODE);
    pm = s.control_c[CC_PARITY_MODE_FIELD +: 2];
    pm_on = pm[1];
    wr_fire = s.aw_have & s.w_have;
    spb_last = (s.control_b[CB_RECEIVE_MODE_FIELD +: 2] == RXM_DOUBLE) ? SPB_DOUBLE_LAST : SPB_NORMAL_LAST;
    mid = 4'(spb_last >> 1) + 4'h1;
    tick_len = ((s.baud >> TICK_SHIFT) == 16'h0) ? 16'h1 : (s.baud >> TICK_SHIFT);
    next_s.rxd_s1 = rxd_i;
    next_s.rxd_s2 = s.rxd_s1;
    next_s.txd_s1 = txd_i;
    next_s.txd_s2 = s.txd_s1;
    // Loop-back takes the shared transmit line
    pin_line = lb ? s.txd_s2 : s.rxd_s2;
    // Pulse is the inverted pin or the event
    ir_pulse = (ir_mode && s.control_c[CC_IRSRC]) ? ir_event_i : ~pin_line;
    rx_line = ir_mode ? s.irdec : pin_line;
    fall = s.line_prev & ~rx_line;
    next_s.line_prev = rx_line;
    next_s.lowcnt = rx_line ? 5'h0 : ((s.lowcnt == 5'h1f) ? s.lowcnt : s.lowcnt + 5'h1);
    measured = s.abcnt + 17'h1;
    first4 = {s.abfirst, 2'b00};
    meas19 = {2'b00, measured};
    diff = (first4 > meas19) ? first4 - meas19 : meas19 - first4;
    sync_ok = (diff <= (meas19 >> 3));
    in_range = (measured >= BAUD_MIN) && (measured <= BAUD_MAX);

    // Pulses shorter than the minimum are dropped
    next_s.irw = ir_pulse ? ((s.irw == 8'hff) ? s.irw : s.irw + 8'h1) : 8'h0;
    if (ir_pulse && ({1'b0, s.irw} + 9'h1 == {1'b0, s.ir_rx_min})) begin
      next_s.irdec = 1'b0;
      next_s.irhold = (s.baud >> IR_HOLD_SHIFT_A) + (s.baud >> IR_HOLD_SHIFT_B);
    end else if (s.irhold != 16'h0) begin
      next_s.irhold = s.irhold - 16'h1;
    end else begin
      next_s.irdec = 1'b1;
    end

    // Register bus
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata_i;
      next_s.w_strb = s_axi_wstrb_i;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = reg_view(s_axi_araddr_i, s);
      next_s.rresp = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr_i == ADDR_RX_DATA) begin
        next_s.rx_valid = 1'b0;
      end
    end
    if (wr_fire) begin
      wv = merge_bytes(reg_view(s.aw_addr, s), s.w_data, s.w_strb);
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (s.aw_addr)
        ADDR_CTRL_A: next_s.control_a = wv[7:0] & CA_MASK;
        ADDR_CTRL_B: next_s.control_b = wv[7:0] & CB_MASK;
        ADDR_CTRL_C: next_s.control_c = wv[7:0];
        ADDR_BAUD: next_s.baud = wv[15:0];
        ADDR_IR_TX: next_s.ir_tx_width = wv[7:0];
        ADDR_IR_RX: next_s.ir_rx_min = wv[7:0];
        ADDR_STATUS: begin
          next_s.wait_for_break_bit = wv[ST_WFB];
          if (s.w_strb[0] && s.w_data[ST_ISF]) begin
            next_s.inconsistent_sync_flag = 1'b0;
          end
        end
        ADDR_TX_DATA: if (s.w_strb[0] && tx_en && s.tst == T_IDLE) begin
          next_s.tsh = s.w_data[7:0];
          // Parity bit from count of ones
          next_s.tpar = parity_of(s.w_data[7:0], pm);
          next_s.tst = s.control_a[CA_RS485] ? T_GUARD : T_START;
          next_s.ttick = tick_len - 16'h1;
          next_s.tsamp = 4'h0;
          next_s.tbit = 4'h0;
        end
        default: ;
      endcase
    end

    // Receiver sample timing
    rtk = (s.rtick == 16'h0);
    if (s.rst inside {R_START, R_DATA, R_PAR, R_STOP}) begin
      next_s.rtick = rtk ? tick_len - 16'h1 : s.rtick - 16'h1;
      if (rtk) begin
        next_s.rsamp = (s.rsamp == spb_last) ? 4'h0 : s.rsamp + 4'h1;
        r_mid = (s.rsamp + 4'h1 == mid);
        r_end = (s.rsamp == spb_last);
      end
    end
    unique case (s.rst)
      R_IDLE: if (rx_en && fall) begin
        next_s.rtick = tick_len - 16'h1;
        next_s.rsamp = 4'h0;
        // Break of any length while waiting
        next_s.rst = (gen && s.wait_for_break_bit) ? R_BREAK : R_START;
      end
      R_START: if (r_mid && rx_line) begin
        next_s.rst = R_IDLE;
      end else if (r_end) begin
        next_s.rst = R_DATA;
        next_s.rbit = 4'h0;
      end
      R_DATA: begin
        if (r_mid) begin
          next_s.rsh = {rx_line, s.rsh[7:1]};
        end
        if (r_end) begin
          next_s.rbit = s.rbit + 4'h1;
          if (s.rbit == DATA_LAST) begin
            next_s.rst = (pm_on && !lin) ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (r_mid) begin
          next_s.rpar_bit = rx_line;
        end
        if (r_end) begin
          next_s.rst = R_STOP;
        end
      end
      R_STOP: if (r_mid) begin
        if (!rx_line && (gen || lin) && s.rsh == 8'h00) begin
          next_s.rst = R_BREAK;
        end else begin
          // Own frames are captured like any other
          rx_deliver = 1'b1;
          next_s.rst = R_IDLE;
          next_s.rx_byte = s.rsh;
          next_s.rx_valid = 1'b1;
          if (lin) begin
            next_s.parity_error_flag = s.pid_next && !pid_ok(s.rsh);
            next_s.pid_next = 1'b0;
          end else begin
            next_s.parity_error_flag = pm_on && (s.rpar_bit != parity_of(s.rsh, pm));
          end
        end
      end
      R_BREAK: if (rx_line) begin
        if (s.lowcnt >= BREAK_MIN || (gen && s.wait_for_break_bit)) begin
          next_s.rst = R_SYNC;
          next_s.wait_for_break_bit = 1'b0;
          next_s.nfall = 3'h0;
          next_s.abcnt = 17'h0;
          next_s.pid_next = 1'b0;
        end else begin
          next_s.rst = R_IDLE;
        end
      end
      R_SYNC: begin
        // Count clocks from start edge to fifth falling edge
        if (s.nfall != 3'h0) begin
          next_s.abcnt = (s.abcnt == AB_SAT) ? s.abcnt : measured;
        end
        if (fall) begin
          next_s.nfall = s.nfall + 3'h1;
          if (s.nfall == 3'h1) begin
            next_s.abfirst = measured;
          end
          if (s.nfall == SYNC_LAST_FALL) begin
            next_s.rst = R_IDLE;
            if (lin) begin
              if (sync_ok && in_range) begin
                next_s.baud = measured[15:0];
                next_s.pid_next = 1'b1;
              end else begin
                next_s.inconsistent_sync_flag = 1'b1;
              end
            end else if (in_range) begin
              next_s.baud = measured[15:0];
            end
          end
        end else if (s.abcnt == AB_SAT) begin
          next_s.rst = R_IDLE;
          next_s.inconsistent_sync_flag = s.inconsistent_sync_flag | lin;
        end
      end
      default: next_s.rst = R_IDLE;
    endcase
    if (!rx_en) begin
      next_s.rst = R_IDLE;
    end

    // Transmitter
    ttk = (s.ttick == 16'h0);
    if (s.tst != T_IDLE) begin
      next_s.ttick = ttk ? tick_len - 16'h1 : s.ttick - 16'h1;
      if (ttk) begin
        next_s.tsamp = s.tsamp + 4'h1;
        if (s.tsamp == spb_last) begin
          next_s.tsamp = 4'h0;
          t_end = 1'b1;
        end
      end
    end
    if (t_end) begin
      unique case (s.tst)
        T_IDLE: ;
        T_GUARD: next_s.tst = T_START;
        T_START: next_s.tst = T_DATA;
        T_DATA: begin
          next_s.tsh = {1'b0, s.tsh[7:1]};
          next_s.tbit = s.tbit + 4'h1;
          if (s.tbit == DATA_LAST) begin
            next_s.tbit = 4'h0;
            next_s.tst = pm_on ? T_PAR : T_STOP;
          end
        end
        T_PAR: next_s.tst = T_STOP;
        T_STOP: if (s.tbit == 4'h0 && s.control_c[CC_STOP2]) begin
          next_s.tbit = 4'h1;
        end else begin
          next_s.tst = T_IDLE;
          next_s.tbit = 4'h0;
        end
      endcase
    end
    case (next_s.tst)
      T_START: tx_bit = 1'b0;
      T_DATA: tx_bit = next_s.tsh[0];
      T_PAR: tx_bit = next_s.tpar;
      default: tx_bit = 1'b1;
    endcase
    next_s.irclk = (t_end || s.tst == T_IDLE) ? 8'h0 : ((s.irclk == 8'hff) ? s.irclk : s.irclk + 8'h1);
    case (s.control_c[CC_IRTX +: 2])
      IRTX_3_16: pulse = !tx_bit && (next_s.tsamp < IR_PULSE_TICKS);
      IRTX_FIXED: pulse = !tx_bit && (next_s.irclk < s.ir_tx_width);
      default: pulse = !tx_bit;
    endcase
    next_s.tpin = ir_mode ? ~pulse : tx_bit;
    // Direction high from guard bit to end of stop
    next_s.dir = s.control_a[CA_RS485] && (next_s.tst != T_IDLE);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.baud <= BAUD_RESET;
      s.ir_rx_min <= IR_RX_MIN_RESET;
      s.rst <= R_IDLE;
      s.tst <= T_IDLE;
      s.tpin <= 1'b1;
      s.irdec <= 1'b1;
      s.line_prev <= 1'b1;
      // Synchronisers start at the idle line level so reset brings no false edge
      s.rxd_s1 <= 1'b1;
      s.rxd_s2 <= 1'b1;
      s.txd_s1 <= 1'b1;
      s.txd_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  a_break_len:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(s.rst == R_SYNC) && !$past(gen && s.wait_for_break_bit) |-> $past(s.lowcnt) >= BREAK_MIN)
    else $error("sync entered after a short break");
  a_wfb_cleared:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(s.rst == R_SYNC) |-> !s.wait_for_break_bit)
    else $error("wait-for-break not cleared by break");
  a_baud_in_range:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $changed(s.baud) && !$past(wr_fire && s.aw_addr == ADDR_BAUD) |-> s.baud >= BAUD_MIN[15:0])
    else $error("measured divisor below range");
  a_isf_keeps_baud:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(s.inconsistent_sync_flag) |-> $stable(s.baud))
    else $error("divisor changed on bad sync");
  a_open_drain_low:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    open_drain_enable_bit && !ir_mode |-> !txd_o && (txd_oe_o == ((s.tst == T_START) || (s.tst == T_DATA && !s.tsh[0])
      || (s.tst == T_PAR && !s.tpar))))
    else $error("open drain drove high");
  a_dir_guard:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(s.tst == T_START) && s.control_a[CA_RS485] |-> $past(direction_output_o, 2))
    else $error("direction not raised before start");
  a_dir_release:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $fell(s.tst != T_IDLE) |-> !direction_output_o)
    else $error("direction still high after frame");
  a_parity_check:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    rx_deliver && pm_on && !lin |=> s.parity_error_flag == (^{$past(s.rsh), $past(s.rpar_bit)} != $past(pm == PAR_ODD)))
    else $error("parity flag wrong");
  a_pid_parity:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    rx_deliver && lin && s.pid_next |=> s.parity_error_flag == !pid_ok(s.rx_byte))
    else $error("identifier parity flag wrong");
endmodule : uab_top
`default_nettype wire

// ==== verification/uab_peer.sv ====
// Remote serial node: sends break and sync frames, captures frames off the line
`timescale 1ns/1ps
`default_nettype none
module uab_peer (
  // Clock and shared line
  input wire logic clock_i,
  input wire logic line_i,
  // Receive pin of the port
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // Break of brk clocks, idle gap, then one character at p clocks per bit
  task automatic send(input int brk, input int p, input logic [7:0] b);
    rxd_o <= 1'b0;
    repeat (brk) @(posedge clock_i);
    rxd_o <= 1'b1;
    repeat (2 * p) @(posedge clock_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (p) @(posedge clock_i);
    end
  endtask : send
  // Data and parity of one frame at 16 clocks per bit, sampled mid-bit
  task automatic grab(output logic [8:0] v);
    while (line_i !== 1'b0) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clock_i);
      v[i] = line_i;
    end
  endtask : grab
endmodule : uab_peer
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench: registers, transmit with parity, single-wire, auto-rate
`timescale 1ns/1ps
`default_nettype none
module testbench import uab_pkg::*;;
  localparam int AB_MODE[5] = '{2, 2, 3, 3, 3};
  localparam int AB_BRK[5] = '{6, 6, 200, 6, 200};
  localparam int AB_P[5] = '{20, 10, 24, 10, 24};
  localparam int AB_CH[5] = '{85, 85, 85, 85, 84};
  logic clk, rst_n, awv, wv, bry, arv, rry, ir_ev, awr, wrd, bv, arr, rv, txo, txoe, dir, rxd;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  logic [31:0] seed = 32'h31;
  logic [7:0] sent_q[$];
  logic od_on = 1'b0, od_bad = 1'b0, oe_seen = 1'b0;
  int fails = 0, checks_done = 0, cycles = 0;
  wire line = txoe ? txo : 1'b1;
  uab_top u_dut (.clock_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .rxd_i(rxd), .txd_i(line), .txd_o(txo), .txd_oe_o(txoe), .direction_output_o(dir), .ir_event_i(ir_ev));
  uab_peer u_peer (.clock_i(clk), .line_i(line), .rxd_o(rxd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awr) begin
        aw = 1;
        awv <= 1'b0;
      end
      if (!w && wrd) begin
        w = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdd;
    r = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, output logic [31:0] d);
    logic [1:0] r;
    do rd(a, d, r); while ((d & m) !== v);
  endtask : poll
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    ir_ev <= ~line;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
    if (od_on) begin
      od_bad <= od_bad | (txo !== 1'b0);
      oe_seen <= oe_seen | txoe;
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [8:0] v;
    int eb;
    {rst_n, awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_BAUD, d, r);
    check(d, {16'h0, BAUD_RESET});
    rd(ADDR_IR_RX, d, r);
    check(d, {24'h0, IR_RX_MIN_RESET});
    rd(8'h3c, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(ADDR_BAUD, 32'h80);
    wr(ADDR_CTRL_A, 32'h2);
    // Double speed never combined with infrared
    wr(ADDR_CTRL_B, 32'h10);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_CTRL_C, {28'h0, 1'b1, i[0], 2'h0});
      wr(ADDR_TX_DATA, {24'h0, seed[7:0]});
      sent_q.push_back(seed[7:0]);
      check({31'h0, dir}, 32'h1);
      u_peer.grab(v);
      check({31'h0, dir}, 32'h1);
      check({23'h0, v}, {23'h0, (^sent_q[0]) ^ i[0], sent_q.pop_front()});
      poll(ADDR_STATUS, 32'h4, 32'h0, d);
      check({31'h0, dir}, 32'h0);
    end
    wr(ADDR_CTRL_A, 32'h3);
    wr(ADDR_CTRL_C, 32'h8);
    wr(ADDR_CTRL_B, 32'h1d);
    seed = xs(seed);
    wr(ADDR_TX_DATA, {24'h0, seed[7:0]});
    od_on = 1'b1;
    poll(ADDR_RX_DATA, 32'h200, 32'h200, d);
    check(d[9:0], {2'h2, seed[7:0]});
    check({od_bad, oe_seen}, 2'h1);
    od_on = 1'b0;
    // Normal speed restored before infrared is chosen
    wr(ADDR_CTRL_B, 32'h18);
    wr(ADDR_IR_RX, 32'h2);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CTRL_C, {24'h0, 1'b0, j[0], IRTX_3_16, 2'h0, COMMUNICATION_MODE_FIELD_INFRARED});
      seed = xs(seed);
      wr(ADDR_TX_DATA, {24'h0, seed[7:0]});
      poll(ADDR_RX_DATA, 32'h200, 32'h200, d);
      check(d[9:0], {2'h2, seed[7:0]});
    end
    wr(ADDR_CTRL_C, 32'h0);
    wr(ADDR_CTRL_A, 32'h0);
    eb = 'h80;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CTRL_B, 32'h8 | AB_MODE[k]);
      wr(ADDR_STATUS, 32'h1);
      // Quiet line so any earlier frame has ended before the break
      repeat (400) @(posedge clk);
      u_peer.send(AB_BRK[k], AB_P[k], AB_CH[k][7:0]);
      // A later falling edge closes a sync field that lacks its fifth one
      if (AB_CH[k] != 85) begin
        u_peer.send(1, 1, 8'hff);
      end
      if ((AB_MODE[k] == 2 || (AB_BRK[k] >= 12 && AB_CH[k] == 85)) && AB_P[k] * 8 >= 'h64)
        eb = AB_P[k] * 8;
      rd(ADDR_BAUD, d, r);
      check(d, eb);
      rd(ADDR_STATUS, d, r);
      check({31'h0, d[1]}, {31'h0, k == 4});
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
